// ==== pkg/bis_defs.svh ====
`ifndef BIS_DEFS_SVH
`define BIS_DEFS_SVH
// ------------------------------------------------------------
// Constants of the boot interface selector
// ------------------------------------------------------------
// Own I2C slave address, 7 bits
`define BIS_I2C_ADDR 7'h6E
// Serial sync byte
`define BIS_SYNC_BYTE 8'h7F
// Clock rate in Hz
`define BIS_CLK_HZ 10000000
// Slowest host rate the timer must cover, in baud
`define BIS_MIN_BAUD 1200
// Fastest supported host rate, in baud
`define BIS_MAX_BAUD 57600
// Shortest legal bit time in cycles, rounded down
`define BIS_MIN_BIT_CYC (`BIS_CLK_HZ / `BIS_MAX_BAUD)
// Width of the edge timer
`define BIS_TMR_W 16
// Sync byte low span is start bit plus seven ones: one low run of 1 bit
`define BIS_SYNC_LOW_BITS 1
// Data bits per serial frame
`define BIS_DATA_BITS 8
// Bits of an I2C address byte, seven address plus direction
`define BIS_I2C_BITS 4'h8
// Watcher count parked after our address was matched, acknowledged or not
`define BIS_I2C_DONE 4'h9
// Option area base address
`define BIS_OPT_BASE 32'h1FFFF800
// Protection level codes
`define BIS_LVL0 2'h0
`define BIS_LVL1 2'h1
`define BIS_LVL2 2'h2
// Level loaded on every reset of the option store
`define BIS_LVL_RST 2'h0
`endif

// ==== pkg/bis_pkg.sv ====
package bis_pkg;
    // Selector state
    typedef enum logic [2:0] {
        BIS_IDLE   = 3'b000,
        BIS_POLL   = 3'b001,
        BIS_BAUD_A = 3'b010,
        BIS_BAUD_B = 3'b011,
        BIS_READY  = 3'b100,
        BIS_APP    = 3'b101
    } bis_state_e;
    // Selected interface
    typedef enum logic [1:0] {
        BIS_SEL_NONE = 2'b00,
        BIS_SEL_I2C  = 2'b01,
        BIS_SEL_SA   = 2'b10,
        BIS_SEL_SB   = 2'b11
    } bis_sel_e;
    // Protection level
    typedef logic [1:0] bis_level_t;
endpackage

// ==== design/bis_sync2.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Two flop synchroniser for a pin level
// ------------------------------------------------------------
module bis_sync2 (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Asynchronous level and its synchronised copy
    input wire logic pin,
    output logic level
);
    logic meta; // First stage, read only by the second

    // Reset to idle high, the line idle level
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta <= 1'b1;
            level <= 1'b1;
        end else begin
            meta <= pin;
            level <= meta;
        end
    end
endmodule

// ==== design/bis_top.sv ====
`timescale 1ns/1ps
`include "bis_defs.svh"
module bis_top
    import bis_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Boot straps
    input wire logic boot_select_pin,
    input wire logic boot_option_bit,
    // Serial receive pins
    input wire logic serial_a_receive,
    input wire logic serial_b_receive,
    // I2C open drain pins
    input wire logic boot_i2c_clock_line_in,
    input wire logic boot_i2c_data_line_in,
    output logic boot_i2c_data_line_out,
    output logic boot_i2c_data_line_oe,
    // Unused serial pins, released to other functions
    output logic serial_pins_released,
    // Protection commands and level
    input wire logic protect_cmd,
    input wire logic unprotect_cmd,
    output bis_level_t protect_level,
    // Boot status
    output logic boot_mode,
    output bis_sel_e selected,
    output logic link_ready,
    output logic serial_a_enable,
    output logic serial_b_enable,
    output logic i2c_enable,
    output logic [`BIS_TMR_W-1:0] baud_divisor
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic sel_pin_s; // Synchronised boot select
    logic opt_s; // Synchronised option bit
    logic ra_s; // Serial A receive level
    logic rb_s; // Serial B receive level
    logic scl_s; // I2C clock level
    logic sda_s; // I2C data level

    bis_sync2 u_s_sel (.ref_clk(ref_clk), .rst_n(rst_n),
        .pin(boot_select_pin), .level(sel_pin_s));
    bis_sync2 u_s_opt (.ref_clk(ref_clk), .rst_n(rst_n),
        .pin(boot_option_bit), .level(opt_s));
    bis_sync2 u_s_ra (.ref_clk(ref_clk), .rst_n(rst_n),
        .pin(serial_a_receive), .level(ra_s));
    bis_sync2 u_s_rb (.ref_clk(ref_clk), .rst_n(rst_n),
        .pin(serial_b_receive), .level(rb_s));
    bis_sync2 u_s_scl (.ref_clk(ref_clk), .rst_n(rst_n),
        .pin(boot_i2c_clock_line_in), .level(scl_s));
    bis_sync2 u_s_sda (.ref_clk(ref_clk), .rst_n(rst_n),
        .pin(boot_i2c_data_line_in), .level(sda_s));

    // ------------------------------------------------------------
    // Selector state
    // ------------------------------------------------------------
    bis_state_e state; // Current state
    bis_state_e next_state; // Next state
    logic [1:0] strap_sh; // Fills over the two synchroniser stages
    // Synchronisers reset high, so straps are valid only once filled
    wire strap_done = strap_sh[1];
    logic ra_d; // Delayed serial A level
    logic rb_d; // Delayed serial B level
    logic [`BIS_TMR_W-1:0] tmr; // Free running edge timer
    logic [`BIS_TMR_W-1:0] t_fall; // Time of start bit fall
    logic [3:0] low_cnt; // Sync byte low runs seen

    // Edge detection on the second synchroniser stage
    wire ra_fall = ra_d & ~ra_s;
    wire rb_fall = rb_d & ~rb_s;
    wire ra_rise = ~ra_d & ra_s;
    wire rb_rise = ~rb_d & rb_s;

    // ------------------------------------------------------------
    // I2C address watcher
    // ------------------------------------------------------------
    logic scl_d; // Delayed clock
    logic sda_d; // Delayed data
    logic i2c_busy; // Between start and stop
    logic [3:0] bit_cnt; // Address bits received
    logic [7:0] shreg; // Address byte shift register
    logic ack_drive; // Pulling data low for acknowledge

    wire i2c_start = scl_s & sda_d & ~sda_s;
    wire i2c_stop = scl_s & ~sda_d & sda_s;
    wire scl_rise = ~scl_d & scl_s;
    wire scl_fall = scl_d & ~scl_s;
    // Address complete and equal to ours, 7-bit mode
    wire addr_done = i2c_busy && (bit_cnt == `BIS_I2C_BITS);
    wire addr_hit = addr_done && (shreg[7:1] == `BIS_I2C_ADDR);

    // Shift in address bits on rising clock after a start
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            i2c_busy <= 1'b0;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            if (i2c_start) begin
                i2c_busy <= 1'b1;
                bit_cnt <= 4'h0;
            end else if (i2c_stop) begin
                i2c_busy <= 1'b0;
            end else if (i2c_busy && scl_rise
                         && bit_cnt < `BIS_I2C_BITS) begin
                shreg <= {shreg[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'h1;
            end else if (addr_done && scl_fall && !ack_drive) begin
                // Miss leaves the watcher waiting for next start
                i2c_busy <= addr_hit;
                bit_cnt <= addr_hit ? `BIS_I2C_DONE : 4'h0;
            end
        end
    end

    // Acknowledge our address for one clock period while I2C is enabled
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_drive <= 1'b0;
        end else if (addr_hit && scl_fall && i2c_enable) begin
            ack_drive <= 1'b1;
        end else if (ack_drive && scl_fall) begin
            ack_drive <= 1'b0;
        end
    end

    assign boot_i2c_data_line_out = 1'b0;
    assign boot_i2c_data_line_oe = ack_drive;

    // ------------------------------------------------------------
    // Next state logic
    // ------------------------------------------------------------
    wire boot_ok = sel_pin_s & opt_s;
    wire sync_done = (low_cnt == 4'(`BIS_SYNC_LOW_BITS));

    always_comb begin
        next_state = state;
        case (state)
            BIS_IDLE: begin
                if (strap_done) begin
                    next_state = boot_ok ? BIS_POLL : BIS_APP;
                end
            end
            BIS_POLL: begin
                // First active interface wins; I2C first
                if (addr_hit) begin
                    next_state = BIS_READY;
                end else if (ra_fall) begin
                    next_state = BIS_BAUD_A;
                end else if (rb_fall) begin
                    next_state = BIS_BAUD_B;
                end
            end
            BIS_BAUD_A, BIS_BAUD_B: begin
                if (sync_done) begin
                    next_state = BIS_READY;
                end
            end
            BIS_READY: next_state = BIS_READY; // Waits for commands
            BIS_APP: next_state = BIS_APP;
            default: next_state = BIS_IDLE;
        endcase
    end

    // State register; strap decision waits for real synced levels
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= BIS_IDLE;
            strap_sh <= 2'h0;
        end else begin
            state <= next_state;
            strap_sh <= {strap_sh[0], 1'b1};
        end
    end

    // ------------------------------------------------------------
    // Selection and enables
    // ------------------------------------------------------------
    // Latch the winner; no other interface may take over
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            selected <= BIS_SEL_NONE;
        end else if (state == BIS_POLL) begin
            if (addr_hit) begin
                selected <= BIS_SEL_I2C;
            end else if (ra_fall) begin
                selected <= BIS_SEL_SA;
            end else if (rb_fall) begin
                selected <= BIS_SEL_SB;
            end
        end
    end

    // All polled while searching, only the winner afterwards
    wire polling = (state == BIS_POLL);
    assign i2c_enable = polling || (selected == BIS_SEL_I2C);
    assign serial_a_enable = polling || (selected == BIS_SEL_SA);
    assign serial_b_enable = polling || (selected == BIS_SEL_SB);
    assign boot_mode = (state != BIS_IDLE) && (state != BIS_APP);
    assign link_ready = (state == BIS_READY);
    assign serial_pins_released = 1'b1;

    // ------------------------------------------------------------
    // Automatic baud detection
    // ------------------------------------------------------------
    // Sync byte 0x7F, LSB first: start bit plus seven ones low run
    // is one bit, so fall to first rise is one bit time.
    wire sel_rise = (state == BIS_BAUD_A) ? ra_rise : rb_rise;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ra_d <= 1'b1;
            rb_d <= 1'b1;
            tmr <= '0;
            t_fall <= '0;
            low_cnt <= 4'h0;
            baud_divisor <= `BIS_TMR_W'(`BIS_CLK_HZ / `BIS_MIN_BAUD);
        end else begin
            ra_d <= ra_s;
            rb_d <= rb_s;
            tmr <= tmr + `BIS_TMR_W'(1);
            if (polling && (ra_fall || rb_fall)) begin
                t_fall <= tmr;
                low_cnt <= 4'h0;
            end else if ((state == BIS_BAUD_A || state == BIS_BAUD_B)
                         && sel_rise && !sync_done) begin
                // Divisor in cycles per bit for 8E1 frames
                baud_divisor <= tmr - t_fall;
                low_cnt <= low_cnt + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Read protection level
    // ------------------------------------------------------------
    // Held as if stored at the option area base
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            protect_level <= `BIS_LVL_RST;
        end else if (link_ready && protect_level != `BIS_LVL2) begin
            if (protect_cmd) begin
                protect_level <= `BIS_LVL1;
            end else if (unprotect_cmd) begin
                protect_level <= `BIS_LVL0;
            end
        end
    end
endmodule

// ==== dv/bis_top_props.sv ====
`timescale 1ns/1ps
`include "bis_defs.svh"
// ------------------------------------------------------------
// Port checker for the boot interface selector
// ------------------------------------------------------------
module bis_top_props
    import bis_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Pins and status
    input wire logic boot_i2c_data_line_out,
    input wire logic boot_i2c_data_line_oe,
    input wire logic serial_pins_released,
    input wire logic protect_cmd,
    input wire logic unprotect_cmd,
    input wire bis_level_t protect_level,
    input wire logic boot_mode,
    input wire bis_sel_e selected,
    input wire logic link_ready,
    input wire logic serial_a_enable,
    input wire logic serial_b_enable,
    input wire logic i2c_enable
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Enables packed as i2c, serial A, serial B
    wire [2:0] ens = {i2c_enable, serial_a_enable, serial_b_enable};
    // Enable pattern owed to the winner
    wire [2:0] win = (selected == BIS_SEL_I2C) ? 3'h4 :
        (selected == BIS_SEL_SA) ? 3'h2 : 3'h1;
    wire lvl_free = protect_level != `BIS_LVL2;
    AST_BOOT: assert property (!boot_mode |-> selected == BIS_SEL_NONE)
        else $error("selection outside boot mode");
    AST_POLL: assert property (boot_mode && selected == BIS_SEL_NONE
        |-> ens == 3'h7)
        else $error("not all interfaces polled");
    AST_OE: assert property (boot_i2c_data_line_oe |-> i2c_enable)
        else $error("data line driven with I2C disabled");
    AST_HOLD: assert property (selected != BIS_SEL_NONE
        |=> $stable(selected))
        else $error("selection changed");
    AST_ONLY: assert property (link_ready |-> ens == win)
        else $error("losing interface still enabled");
    AST_FREE: assert property (serial_pins_released)
        else $error("serial side pins claimed");
    AST_LVL: assert property (protect_level != 2'h3)
        else $error("protection level out of range");
    AST_PROT: assert property (link_ready && protect_cmd && !unprotect_cmd
        && lvl_free |=> protect_level == `BIS_LVL1)
        else $error("protect did not give level 1");
    AST_UNPR: assert property (link_ready && unprotect_cmd && !protect_cmd
        && lvl_free |=> protect_level == `BIS_LVL0)
        else $error("unprotect did not give level 0");
    AST_IDLE: assert property (!link_ready |=> $stable(protect_level))
        else $error("level changed before link ready");
    AST_OD: assert property (boot_i2c_data_line_out == 1'b0)
        else $error("open drain output not low");
    // Main scenarios
    COV_I2C: cover property (link_ready && selected == BIS_SEL_I2C);
    COV_SA: cover property (link_ready && selected == BIS_SEL_SA);
    COV_SB: cover property (link_ready && selected == BIS_SEL_SB);
endmodule
bind bis_top bis_top_props bis_top_props_i (.ref_clk, .rst_n,
    .boot_i2c_data_line_out, .boot_i2c_data_line_oe, .serial_pins_released,
    .protect_cmd, .unprotect_cmd, .protect_level, .boot_mode, .selected,
    .link_ready, .serial_a_enable, .serial_b_enable, .i2c_enable);

// ==== dv/bis_host.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host model: I2C master and serial terminal
// ------------------------------------------------------------
module bis_host (
    // Clock
    input wire logic ref_clk,
    // Device pull on the data line
    input wire logic sda_oe,
    // Lines toward the device
    output logic rx_a,
    output logic rx_b,
    output logic scl,
    output wire logic sda
);
    localparam int H = 12; // Half SCL period, about 400 kHz
    logic sda_h; // Host side of data line, 1 = released
    // Pull-up: line low when either party pulls
    assign sda = sda_h & ~sda_oe;
    // Unused receive lines held high, never floating
    initial begin
        rx_a = 1'b1;
        rx_b = 1'b1;
        scl = 1'b1;
        sda_h = 1'b1;
    end
    // Remap and vector table are the loaded image's duty
    // no pin of this block carries them, so the host sends no image
    // Wait n falling edges
    task automatic gap(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Sync frame: start, 0x7F, even parity, stop
    task automatic sync(input bit b, input int t);
        logic [10:0] f;
        f = {1'b1, 1'b1, 8'h7F, 1'b0};
        for (int i = 0; i < 11; i++) begin
            if (b) rx_b = f[i];
            else rx_a = f[i];
            gap(t);
        end
    endtask
    // Start, address with write bit, acknowledge slot, stop
    task automatic addr(input logic [6:0] a, output logic ack);
        logic [7:0] v;
        v = {a, 1'b0};
        sda_h = 1'b0;
        gap(H);
        scl = 1'b0;
        gap(2);
        for (int i = 7; i >= 0; i--) begin
            sda_h = v[i];
            gap(H);
            scl = 1'b1;
            gap(H);
            scl = 1'b0;
            gap(2);
        end
        sda_h = 1'b1;
        gap(H);
        scl = 1'b1;
        gap(H / 2);
        ack = ~sda;
        gap(H / 2);
        scl = 1'b0;
        gap(2);
        sda_h = 1'b0;
        gap(H);
        scl = 1'b1;
        gap(H);
        sda_h = 1'b1;
        gap(H);
    endtask
endmodule

// ==== dv/bis_top_test.sv ====
`timescale 1ns/1ps
`include "bis_defs.svh"
// ------------------------------------------------------------
// Testbench of the boot interface selector
// ------------------------------------------------------------
module bis_top_test;
    import bis_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, bsel = 1'b0, bopt = 1'b0;
    logic pcmd = 1'b0, ucmd = 1'b0, ack;
    logic rxa, rxb, scl, sda, oe, dout, rel, bmode, lrdy, ena, enb, eni;
    bis_level_t lvl;
    bis_sel_e sel;
    logic [`BIS_TMR_W-1:0] div;
    int failures = 0, n_compared = 0;
    // Clock, 100 ns period
    initial forever #50 ref_clk = ~ref_clk;
    bis_top bis_top_i (.ref_clk, .rst_n, .boot_select_pin(bsel),
        .boot_option_bit(bopt), .serial_a_receive(rxa),
        .serial_b_receive(rxb), .boot_i2c_clock_line_in(scl),
        .boot_i2c_data_line_in(sda), .boot_i2c_data_line_out(dout),
        .boot_i2c_data_line_oe(oe), .serial_pins_released(rel),
        .protect_cmd(pcmd), .unprotect_cmd(ucmd), .protect_level(lvl),
        .boot_mode(bmode), .selected(sel), .link_ready(lrdy),
        .serial_a_enable(ena), .serial_b_enable(enb), .i2c_enable(eni),
        .baud_divisor(div));
    bis_host bis_host_i (.ref_clk, .sda_oe(oe), .rx_a(rxa), .rx_b(rxb),
        .scl, .sda);
    // Compare and count
    task automatic chk(input string nm, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Reset with given straps, held 3 cycles
    task automatic rst(input logic s, o);
        @(negedge ref_clk);
        rst_n = 1'b0;
        bsel = s;
        bopt = o;
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (6) @(negedge ref_clk);
    endtask
    // Bounded wait for link ready
    task automatic wait_rdy;
        for (int i = 0; i < 400 && lrdy !== 1'b1; i++) @(negedge ref_clk);
    endtask
    // One-cycle command pulse, level checked after it
    task automatic cmd(input bit p, input logic [1:0] e);
        pcmd = p;
        ucmd = !p;
        @(negedge ref_clk);
        pcmd = 1'b0;
        ucmd = 1'b0;
        @(negedge ref_clk);
        chk("level", e, lvl);
    endtask
    // Closing report
    task automatic give_verdict;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (30000) @(posedge ref_clk);
        failures++;
        give_verdict();
    end
    // Test sequence
    initial begin
        rst(1'b0, 1'b1);
        chk("boot_mode", 0, bmode);
        rst(1'b1, 1'b0);
        chk("boot_mode", 0, bmode);
        rst(1'b1, 1'b1);
        chk("boot_mode", 1, bmode);
        chk("divisor", `BIS_CLK_HZ / `BIS_MIN_BAUD, div);
        chk("enables", 3'h7, {eni, ena, enb});
        chk("released", 1, rel);
        cmd(1'b1, `BIS_LVL0);
        bis_host_i.addr(7'h50, ack);
        chk("ack", 0, ack);
        chk("selected", BIS_SEL_NONE, sel);
        bis_host_i.addr(`BIS_I2C_ADDR, ack);
        chk("ack", 1, ack);
        chk("selected", BIS_SEL_I2C, sel);
        bis_host_i.sync(1'b0, 174);
        chk("selected", BIS_SEL_I2C, sel);
        chk("enables", 3'h4, {eni, ena, enb});
        cmd(1'b1, `BIS_LVL1);
        cmd(1'b0, `BIS_LVL0);
        for (int p = 0; p < 2; p++) begin
            rst(1'b1, 1'b1);
            bis_host_i.sync(p[0], 174 + 26 * p);
            wait_rdy();
            chk("ready", 1, lrdy);
            chk("selected", p ? BIS_SEL_SB : BIS_SEL_SA, sel);
            chk("divisor", 174 + 26 * p, div);
            bis_host_i.addr(`BIS_I2C_ADDR, ack);
            chk("ack", 0, ack);
            chk("enables", p ? 3'h1 : 3'h2, {eni, ena, enb});
        end
        give_verdict();
    end
endmodule
